// ### hflc_pkg.sv
// Constants and decode functions for the feedback loop tuning register.
// Assumes the serial control interface delivers byte-wide register accesses
// as single-cycle strobes on sys_clk.
`default_nettype none

package hflc_pkg;

    // Register location and reset value
    localparam logic [7:0] FLT_ADDR = 8'h23;
    localparam logic [7:0] FLT_RESET = 8'h36;

    // Field positions
    localparam int GATE_BIT = 7;
    localparam int BRAKE_MSB = 6;
    localparam int BRAKE_LSB = 4;
    localparam int LOOP_MSB = 3;
    localparam int LOOP_LSB = 2;
    localparam int BEMF_MSB = 1;
    localparam int BEMF_LSB = 0;

    // Field defaults
    localparam logic GATE_RESET = 1'b0;
    localparam logic [2:0] BRAKE_RESET = 3'h3;
    localparam logic [1:0] LOOP_RESET = 2'h1;
    localparam logic [1:0] BEMF_RESET = 2'h2;

    // Brake ratio code that removes feedback while braking
    localparam logic [2:0] BRAKE_OFF_CODE = 3'h7;

    // Noise gate thresholds in percent of supply, and drive full scale
    localparam logic [15:0] GATE_LO_PCT = 16'h0004;
    localparam logic [15:0] GATE_HI_PCT = 16'h0008;
    localparam logic [15:0] PCT_SCALE = 16'h0064;
    localparam logic [15:0] DRIVE_FULL_SCALE = 16'h00ff;

    // Braking to driving gain ratio for each code
    function automatic logic [4:0] hflc_brake_ratio(input logic [2:0] code);
        case (code)
            3'h0: hflc_brake_ratio = 5'h01;
            3'h1: hflc_brake_ratio = 5'h02;
            3'h2: hflc_brake_ratio = 5'h03;
            3'h3: hflc_brake_ratio = 5'h04;
            3'h4: hflc_brake_ratio = 5'h06;
            3'h5: hflc_brake_ratio = 5'h08;
            3'h6: hflc_brake_ratio = 5'h10;
            default: hflc_brake_ratio = 5'h00;
        endcase
    endfunction : hflc_brake_ratio

    // Back-EMF amplifier gain times 100, resonant or eccentric-mass mode
    function automatic logic [11:0] hflc_bemf_x100(input logic [1:0] code, input logic erm);
        case ({erm, code})
            3'h0: hflc_bemf_x100 = 12'h1f4;
            3'h1: hflc_bemf_x100 = 12'h3e8;
            3'h2: hflc_bemf_x100 = 12'h7d0;
            3'h3: hflc_bemf_x100 = 12'hbb8;
            3'h4: hflc_bemf_x100 = 12'h022;
            3'h5: hflc_bemf_x100 = 12'h069;
            3'h6: hflc_bemf_x100 = 12'h0b6;
            default: hflc_bemf_x100 = 12'h190;
        endcase
    endfunction : hflc_bemf_x100

endpackage : hflc_pkg

`default_nettype wire

// ### hflc_link_if.sv
// Carrier between the tuning register and its output shaping logic.
// Both ends run on sys_clk; the shaping end is purely combinational.
`timescale 1ns/1ps
`default_nettype none

interface hflc_link_if #(
    parameter int DW = 8
);
    // Configuration and commanded drive from the register end
    logic gate_sel;
    logic [2:0] brake_code;
    logic [1:0] loop_code;
    logic [DW-1:0] drive_mag;
    logic drive_neg;
    // Shaped results back to the register end
    logic [DW-1:0] gated_mag;
    logic gated_neg;
    logic [4:0] brake_ratio;
    logic brake_fb_en;
    logic [1:0] loop_shift;

    modport cfg (
        output gate_sel, brake_code, loop_code, drive_mag, drive_neg,
        input gated_mag, gated_neg, brake_ratio, brake_fb_en, loop_shift
    );
    modport shape (
        input gate_sel, brake_code, loop_code, drive_mag, drive_neg,
        output gated_mag, gated_neg, brake_ratio, brake_fb_en, loop_shift
    );
endinterface : hflc_link_if

`default_nettype wire

// ### hflc_shape.sv
// Noise gate on the commanded drive and decode of the loop tuning fields.
// Assumes drive_mag is an unsigned magnitude where full scale is the supply.
`timescale 1ns/1ps
`default_nettype none

module hflc_shape #(
    parameter int DW = 8
) (
    hflc_link_if.shape lnk
);

    logic [15:0] mag_scaled;
    logic [15:0] gate_level;
    logic below_gate;

    always_comb begin
        mag_scaled = 16'(lnk.drive_mag) * hflc_pkg::PCT_SCALE;
        gate_level = hflc_pkg::DRIVE_FULL_SCALE *
                     (lnk.gate_sel ? hflc_pkg::GATE_HI_PCT : hflc_pkg::GATE_LO_PCT);
        below_gate = mag_scaled < gate_level;
    end

    always_comb begin
        lnk.gated_mag = below_gate ? '0 : lnk.drive_mag;
        lnk.gated_neg = below_gate ? 1'b0 : lnk.drive_neg;
    end

    // ratio decode; code 7 removes brake feedback
    always_comb begin
        lnk.brake_ratio = hflc_pkg::hflc_brake_ratio(lnk.brake_code);
        lnk.brake_fb_en = lnk.brake_code != hflc_pkg::BRAKE_OFF_CODE;
    end

    // higher gain code gives a smaller shift, so a bigger loop step
    always_comb begin
        lnk.loop_shift = ~lnk.loop_code;
    end

endmodule : hflc_shape

`default_nettype wire

// ### hflc_loop_cfg.sv
// Feedback loop tuning register with its noise gate and gain decode outputs.
// Assumes the serial control slave presents decoded byte accesses as strobes,
// the calibration engine pulses cal_done, and all inputs are sync to sys_clk.
// Field outputs follow a write by two edges; the loop must not sample them
// in the cycle right after the strobe or it acts on stale tuning.
// A read and a write in one cycle return the value from before the write.
// Cal_done beats a same-cycle host write for the gain bits only.
// The reset gain value assumes resonant mode until the first clock edge.
// Gate compare is exact against the percentage of a 255 full scale.
// Brake code 7 zeroes the ratio output as well as clearing the enable.
//
// What this block does
// - Bit 7 picks a 4% or 8% gate; smaller drive forces zero output.
// - Bits 6-4 pick brake gain ratio 1,2,3,4,6,8,16; default code 3.
// - Brake ratio code 7 removes feedback while braking.
// - Bits 3-2 set feedback loop gain; default code 1.
// - Higher loop gain codes settle faster but are less stable.
// - Bits 1-0 set back-EMF gain per mode; calibration overwrites, host may rewrite.
`timescale 1ns/1ps
`default_nettype none

module hflc_loop_cfg #(
    parameter int DW = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic reg_rd_hit,
    input wire logic cal_done,
    input wire logic [1:0] cal_backemf_amp_gain,
    input wire logic erm_mode,
    input wire logic [DW-1:0] drive_mag,
    input wire logic drive_neg,
    output logic [DW-1:0] out_mag,
    output logic out_neg,
    output logic [4:0] brake_feedback_ratio,
    output logic brake_fb_en,
    output logic [1:0] loop_gain,
    output logic [1:0] loop_step_shift,
    output logic [1:0] backemf_amp_gain,
    output logic [11:0] backemf_gain_x100,
    output logic output_gate_level
);

    // Register fields
    logic gate_sel;
    logic [2:0] brake_code;
    logic [1:0] loop_code;
    logic [1:0] bemf_code;
    logic next_gate_sel;
    logic [2:0] next_brake_code;
    logic [1:0] next_loop_code;
    logic [1:0] next_bemf_code;

    // Read port
    logic [7:0] next_reg_rdata;
    logic next_reg_rd_hit;

    // Registered outputs
    logic [DW-1:0] next_out_mag;
    logic next_out_neg;
    logic [4:0] next_brake_feedback_ratio;
    logic next_brake_fb_en;
    logic [1:0] next_loop_step_shift;
    logic [11:0] next_backemf_gain_x100;
    logic [1:0] next_loop_gain;
    logic [1:0] next_backemf_amp_gain;
    logic next_output_gate_level;

    // Decoded strobes and assembled register
    logic wr_hit;
    logic rd_hit;
    logic [7:0] reg_value;

    // Output values held in reset, derived from the field defaults
    localparam logic [4:0] RATIO_AT_RESET = hflc_pkg::hflc_brake_ratio(hflc_pkg::BRAKE_RESET);
    localparam logic BRAKE_FB_AT_RESET = hflc_pkg::BRAKE_RESET != hflc_pkg::BRAKE_OFF_CODE;
    localparam logic [1:0] SHIFT_AT_RESET = ~hflc_pkg::LOOP_RESET;
    localparam logic [11:0] GAIN_X100_AT_RESET = hflc_pkg::hflc_bemf_x100(hflc_pkg::BEMF_RESET, 1'b0);

    // Address decode shared by the write and read paths
    function automatic logic flt_addr_match(input logic [7:0] addr);
        flt_addr_match = addr == hflc_pkg::FLT_ADDR;
    endfunction : flt_addr_match

    // Carrier to the shaping logic
    hflc_link_if #(.DW(DW)) lnk ();

    hflc_shape #(.DW(DW)) u_shape (
        .lnk(lnk)
    );

    // Field view to the shaping logic
    assign lnk.gate_sel = gate_sel;
    assign lnk.brake_code = brake_code;
    assign lnk.loop_code = loop_code;
    assign lnk.drive_mag = drive_mag;
    assign lnk.drive_neg = drive_neg;

    always_comb begin
        reg_value = '0;
        reg_value[hflc_pkg::GATE_BIT] = gate_sel;
        reg_value[hflc_pkg::BRAKE_MSB:hflc_pkg::BRAKE_LSB] = brake_code;
        reg_value[hflc_pkg::LOOP_MSB:hflc_pkg::LOOP_LSB] = loop_code;
        reg_value[hflc_pkg::BEMF_MSB:hflc_pkg::BEMF_LSB] = bemf_code;
    end

    // Register address decode for both strobes
    always_comb begin
        wr_hit = reg_wr_en && flt_addr_match(reg_addr);
        rd_hit = reg_rd_en && flt_addr_match(reg_addr);
    end

    // Write decode; a host write loads every field, but bemf_code only when cal_done is low
    always_comb begin
        // Hold every field unless written
        next_gate_sel = gate_sel;
        next_brake_code = brake_code;
        next_loop_code = loop_code;
        next_bemf_code = bemf_code;
        if (wr_hit) begin
            next_gate_sel = reg_wdata[hflc_pkg::GATE_BIT];
            next_brake_code = reg_wdata[hflc_pkg::BRAKE_MSB:hflc_pkg::BRAKE_LSB];
            next_loop_code = reg_wdata[hflc_pkg::LOOP_MSB:hflc_pkg::LOOP_LSB];
            next_bemf_code = reg_wdata[hflc_pkg::BEMF_MSB:hflc_pkg::BEMF_LSB];
        end
        // calibration result wins a same-cycle write
        if (cal_done) begin
            next_bemf_code = cal_backemf_amp_gain;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_sel <= hflc_pkg::GATE_RESET;
            brake_code <= hflc_pkg::BRAKE_RESET;
            loop_code <= hflc_pkg::LOOP_RESET;
            bemf_code <= hflc_pkg::BEMF_RESET;
        end else begin
            gate_sel <= next_gate_sel;
            brake_code <= next_brake_code;
            loop_code <= next_loop_code;
            bemf_code <= next_bemf_code;
        end
    end

    // Read data one cycle after the strobe; other addresses return zero
    always_comb begin
        next_reg_rd_hit = rd_hit;
        next_reg_rdata = rd_hit ? reg_value : 8'h00;
    end

    // Read port flops; both fall back to idle after one cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rd_hit <= 1'b0;
        end else begin
            reg_rdata <= next_reg_rdata;
            reg_rd_hit <= next_reg_rd_hit;
        end
    end

    // Output values from the current fields and drive command
    always_comb begin
        next_out_mag = lnk.gated_mag;
        next_out_neg = lnk.gated_neg;
        next_brake_feedback_ratio = lnk.brake_ratio;
        next_brake_fb_en = lnk.brake_fb_en;
        next_loop_step_shift = lnk.loop_shift;
        // gain meaning depends on actuator mode
        next_backemf_gain_x100 = hflc_pkg::hflc_bemf_x100(bemf_code, erm_mode);
        next_loop_gain = loop_code;
        next_backemf_amp_gain = bemf_code;
        next_output_gate_level = gate_sel;
    end

    // Output flops; reset values follow the field defaults
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_mag <= '0;
            out_neg <= 1'b0;
            brake_feedback_ratio <= RATIO_AT_RESET;
            brake_fb_en <= BRAKE_FB_AT_RESET;
            loop_gain <= hflc_pkg::LOOP_RESET;
            loop_step_shift <= SHIFT_AT_RESET;
            backemf_amp_gain <= hflc_pkg::BEMF_RESET;
            backemf_gain_x100 <= GAIN_X100_AT_RESET;
            output_gate_level <= hflc_pkg::GATE_RESET;
        end else begin
            out_mag <= next_out_mag;
            out_neg <= next_out_neg;
            brake_feedback_ratio <= next_brake_feedback_ratio;
            brake_fb_en <= next_brake_fb_en;
            loop_gain <= next_loop_gain;
            loop_step_shift <= next_loop_step_shift;
            backemf_amp_gain <= next_backemf_amp_gain;
            backemf_gain_x100 <= next_backemf_gain_x100;
            output_gate_level <= next_output_gate_level;
        end
    end

endmodule : hflc_loop_cfg

`default_nettype wire

// ### hflc_chk.sv
// Port assertions for the feedback loop tuning register.
// Assumes binding onto hflc_loop_cfg; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hflc_chk #(parameter int DW = 8) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_hit,
    input wire logic cal_done,
    input wire logic [1:0] cal_backemf_amp_gain,
    input wire logic [DW-1:0] drive_mag,
    input wire logic [DW-1:0] out_mag,
    input wire logic out_neg,
    input wire logic [4:0] brake_feedback_ratio,
    input wire logic brake_fb_en,
    input wire logic [1:0] loop_gain,
    input wire logic [1:0] loop_step_shift,
    input wire logic [1:0] backemf_amp_gain,
    input wire logic output_gate_level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_read_hit:
        assert property (reg_rd_en && reg_addr == 8'h23 |=> reg_rd_hit) else $error("read hit missing");
    a_read_miss:
        assert property (reg_rd_en && reg_addr != 8'h23 |=> !reg_rd_hit && reg_rdata == 8'h00) else $error("bad miss");
    a_gate_low:
        assert property (drive_mag <= 10 |=> out_mag == 0 && !out_neg) else $error("small drive passed");
    a_gate_mid:
        assert property (drive_mag inside {[11:20]} |=> out_mag == (output_gate_level ? 0 : $past(drive_mag)))
            else $error("gate band wrong");
    a_gate_high:
        assert property (drive_mag > 20 |=> out_mag == $past(drive_mag)) else $error("large drive gated");
    a_brake_off:
        assert property (brake_fb_en == (brake_feedback_ratio != 5'h00)) else $error("brake enable wrong");
    a_loop_speed:
        assert property (loop_step_shift == ~loop_gain) else $error("loop shift wrong");
    a_cal_load:
        assert property (cal_done |=> ##1 backemf_amp_gain == $past(cal_backemf_amp_gain, 2)) else $error("cal gain lost");
    a_write_fields:
        assert property (reg_wr_en && reg_addr == 8'h23 && !cal_done |=> ##1
            loop_gain == $past(reg_wdata[3:2], 2) && output_gate_level == $past(reg_wdata[7], 2))
            else $error("write not applied");
endmodule : hflc_chk
bind hflc_loop_cfg hflc_chk #(.DW(DW)) hflc_chk_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata),
    .reg_rd_hit(reg_rd_hit),
    .cal_done(cal_done),
    .cal_backemf_amp_gain(cal_backemf_amp_gain),
    .drive_mag(drive_mag),
    .out_mag(out_mag),
    .out_neg(out_neg),
    .brake_feedback_ratio(brake_feedback_ratio),
    .brake_fb_en(brake_fb_en),
    .loop_gain(loop_gain),
    .loop_step_shift(loop_step_shift),
    .backemf_amp_gain(backemf_amp_gain),
    .output_gate_level(output_gate_level)
);
`default_nettype wire

// ### hflc_host_model.sv
// Host side of the control interface: byte register accesses.
// Assumes one-cycle strobes launched at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module hflc_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_hit,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end
    // Write strobe, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // Read strobe, answer taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
        h = reg_rd_hit;
    endtask : rd
endmodule : hflc_host_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the feedback loop tuning register.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_mag, out_mag;
    logic reg_wr_en, reg_rd_en, reg_rd_hit, cal_done, erm_mode, drive_neg, out_neg;
    logic brake_fb_en, output_gate_level;
    logic [1:0] cal_backemf_amp_gain, loop_gain, loop_step_shift, backemf_amp_gain;
    logic [4:0] brake_feedback_ratio;
    logic [11:0] backemf_gain_x100;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    hflc_loop_cfg #(.DW(8)) hflc_loop_cfg_inst (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata),
        .reg_rd_hit(reg_rd_hit),
        .cal_done(cal_done),
        .cal_backemf_amp_gain(cal_backemf_amp_gain),
        .erm_mode(erm_mode),
        .drive_mag(drive_mag),
        .drive_neg(drive_neg),
        .out_mag(out_mag),
        .out_neg(out_neg),
        .brake_feedback_ratio(brake_feedback_ratio),
        .brake_fb_en(brake_fb_en),
        .loop_gain(loop_gain),
        .loop_step_shift(loop_step_shift),
        .backemf_amp_gain(backemf_amp_gain),
        .backemf_gain_x100(backemf_gain_x100),
        .output_gate_level(output_gate_level)
    );
    hflc_host_model hflc_host_model_inst (
        .sys_clk(sys_clk),
        .reg_rdata(reg_rdata),
        .reg_rd_hit(reg_rd_hit),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en)
    );
    // Clock and hang guard
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask : settle
    task automatic t_reset();
        logic [7:0] d;
        logic h;
        @(negedge sys_clk);
        arst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        hflc_host_model_inst.rd(8'h23, d, h);
        chk("reset value", 12'h036, {4'h0, d});
        chk("read hit", 12'h001, {11'h0, h});
        chk("ratio", 12'h004, {7'h0, brake_feedback_ratio});
        chk("loop gain", 12'h001, {10'h0, loop_gain});
        chk("backemf_amp_gain", 12'h002, {10'h0, backemf_amp_gain});
        chk("shift", 12'h002, {10'h0, loop_step_shift});
        chk("brake fb", 12'h001, {11'h0, brake_fb_en});
        chk("gate level", 12'h000, {11'h0, output_gate_level});
    endtask : t_reset
    task automatic t_brake();
        logic [4:0] tbl [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
        logic [7:0] d;
        logic h;
        for (int c = 0; c < 8; c++) begin
            hflc_host_model_inst.wr(8'h23, {1'b0, c[2:0], 4'h6});
            settle();
            chk("ratio", {7'h0, tbl[c]}, {7'h0, brake_feedback_ratio});
            chk("brake fb", {11'h0, c != 7}, {11'h0, brake_fb_en});
            hflc_host_model_inst.rd(8'h23, d, h);
            chk("readback", {5'h0, c[2:0], 4'h6}, {4'h0, d});
        end
    endtask : t_brake
    task automatic t_loop();
        for (int g = 0; g < 4; g++) begin
            hflc_host_model_inst.wr(8'h23, {4'h3, g[1:0], 2'h2});
            settle();
            chk("loop gain", g[11:0], {10'h0, loop_gain});
            chk("loop shift", 12'(3 - g), {10'h0, loop_step_shift});
        end
    endtask : t_loop
    task automatic drv(input logic [7:0] m, input logic [7:0] e);
        @(negedge sys_clk);
        drive_mag = m;
        drive_neg = 1'b1;
        @(negedge sys_clk);
        chk("out mag", {4'h0, e}, {4'h0, out_mag});
        chk("out neg", {11'h0, e != 0}, {11'h0, out_neg});
    endtask : drv
    task automatic t_gate();
        hflc_host_model_inst.wr(8'h23, 8'h36);
        settle();
        chk("gate level", 12'h000, {11'h0, output_gate_level});
        drv(8'd10, 8'd0);
        drv(8'd11, 8'd11);
        hflc_host_model_inst.wr(8'h23, 8'hb6);
        settle();
        chk("gate level", 12'h001, {11'h0, output_gate_level});
        drv(8'd20, 8'd0);
        drv(8'd21, 8'd21);
    endtask : t_gate
    task automatic t_cal();
        logic [11:0] tbl [8] = '{12'h1f4, 12'h3e8, 12'h7d0, 12'hbb8, 12'h022, 12'h069, 12'h0b6, 12'h190};
        logic [7:0] d;
        logic h;
        hflc_host_model_inst.wr(8'h23, 8'h36);
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            erm_mode = i[2];
            cal_done = 1'b1;
            cal_backemf_amp_gain = i[1:0];
            @(negedge sys_clk);
            cal_done = 1'b0;
            cal_backemf_amp_gain = ~i[1:0];
            settle();
            chk("cal gain", {10'h0, i[1:0]}, {10'h0, backemf_amp_gain});
            chk("gain x100", tbl[i], backemf_gain_x100);
        end
        // Calibration and a host write in one cycle: gain bits take the calibration
        fork
            hflc_host_model_inst.wr(8'h23, 8'h38);
            begin
                @(negedge sys_clk);
                cal_done = 1'b1;
                cal_backemf_amp_gain = 2'h3;
                @(negedge sys_clk);
                cal_done = 1'b0;
            end
        join
        settle();
        chk("cal wins gain", 12'h003, {10'h0, backemf_amp_gain});
        chk("write keeps loop", 12'h002, {10'h0, loop_gain});
        hflc_host_model_inst.rd(8'h23, d, h);
        chk("cal readback", 12'h03b, {4'h0, d});
        hflc_host_model_inst.wr(8'h23, 8'h35);
        settle();
        chk("host gain", 12'h001, {10'h0, backemf_amp_gain});
    endtask : t_cal
    task automatic t_unmapped();
        logic [7:0] d;
        logic h;
        hflc_host_model_inst.wr(8'h24, 8'hff);
        hflc_host_model_inst.rd(8'h24, d, h);
        chk("miss data", 12'h000, {4'h0, d});
        chk("miss hit", 12'h000, {11'h0, h});
        hflc_host_model_inst.rd(8'h23, d, h);
        chk("kept", 12'h035, {4'h0, d});
    endtask : t_unmapped
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        drive_mag = 8'h00;
        drive_neg = 1'b0;
        cal_done = 1'b0;
        cal_backemf_amp_gain = 2'h0;
        erm_mode = 1'b0;
        t_reset();
        t_brake();
        t_loop();
        t_gate();
        t_cal();
        t_unmapped();
        t_reset();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
